// *** hdl/cmd_decode_pkg.sv ***
/*
 * shared constants and types for the register access command decoder:
 * command byte layout, reset value, target index codes and target kinds.
 * assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package cmd_decode_pkg;

    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int CMD_WIDTH = 8; // one command byte per transaction
    localparam int START_BIT = 7; // active-low start flag
    localparam int DIR_BIT = 6; // 0 write, 1 read
    localparam int IDX_MSB = 5; // target index field top bit
    localparam int CNT_WIDTH = 3; // bit counter width for one byte
    localparam logic [2:0] LAST_BIT = 3'h7; // count value of the eighth bit
    localparam logic [7:0] CMD_RESET = 8'h00; // command register reset value
    localparam logic [3:0] NUM_RESET = 4'h0; // target number reset value

    // ------------------------------------------------------------
    // target index codes (six bits)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_STATUS = 6'h00;
    localparam logic [5:0] IDX_ADC_MODE = 6'h01;
    localparam logic [5:0] IDX_IF_MODE = 6'h02;
    localparam logic [5:0] IDX_CHECKSUM = 6'h03;
    localparam logic [5:0] IDX_DATA = 6'h04;
    localparam logic [5:0] IDX_PORT_CFG = 6'h06;
    localparam logic [5:0] IDX_IDENT = 6'h07;
    localparam logic [1:0] GRP_CHANNEL = 2'h1; // index[5:4] for channels 0..15
    localparam logic [2:0] GRP_SETUP = 3'h4; // index[5:3] for setups 0..7
    localparam logic [2:0] GRP_FILTER = 3'h5; // index[5:3] for filters 0..7
    localparam logic [2:0] GRP_OFFSET = 3'h6; // index[5:3] for offsets 0..7
    localparam logic [2:0] GRP_GAIN = 3'h7; // index[5:3] for gains 0..7

    // ------------------------------------------------------------
    // decoded target kinds
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        KIND_NONE = 4'h0,
        KIND_STATUS = 4'h1,
        KIND_ADC_MODE = 4'h2,
        KIND_IF_MODE = 4'h3,
        KIND_CHECKSUM = 4'h4,
        KIND_DATA = 4'h5,
        KIND_PORT_CFG = 4'h6,
        KIND_IDENT = 4'h7,
        KIND_CHANNEL = 4'h8,
        KIND_SETUP = 4'h9,
        KIND_FILTER = 4'ha,
        KIND_OFFSET = 4'hb,
        KIND_GAIN = 4'hc
    } target_kind_t;

    // transaction phase
    typedef enum logic [0:0] {
        PH_COMMAND = 1'b0,
        PH_TRANSFER = 1'b1
    } phase_t;

endpackage : cmd_decode_pkg

// *** hdl/cmd_decoder.sv ***
/*
 * command decoder: receives the opening byte of every register transaction
 * from the serial pins, checks its start flag, latches it and routes the
 * next transfer to the selected register as a read or a write.
 * assumes serial clock, chip select and data in arrive asynchronously and
 * much slower than sys_clk; register logic downstream pulses xfer_done.
 */
`timescale 1ns/1ps

module cmd_decoder
    import cmd_decode_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // serial pins from the host
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // downstream register logic
    input wire logic xfer_done,
    // decoded command
    output logic [cmd_decode_pkg::CMD_WIDTH-1:0] command_q,
    output logic cmd_strobe_q,
    output logic bad_start_q,
    output cmd_decode_pkg::target_kind_t target_kind_q,
    output logic [3:0] target_num_q,
    output logic read_active_q,
    output logic write_active_q
);
    import cmd_decode_pkg::*;

    // ------------------------------------------------------------
    // target decode
    // ------------------------------------------------------------
    // maps a six-bit index onto a kind; unlisted codes give none
    function automatic target_kind_t decode_kind(input logic [5:0] idx);
        target_kind_t k;
        k = KIND_NONE;
        if (idx == IDX_STATUS) k = KIND_STATUS;
        else if (idx == IDX_ADC_MODE) k = KIND_ADC_MODE;
        else if (idx == IDX_IF_MODE) k = KIND_IF_MODE;
        else if (idx == IDX_CHECKSUM) k = KIND_CHECKSUM;
        else if (idx == IDX_DATA) k = KIND_DATA;
        else if (idx == IDX_PORT_CFG) k = KIND_PORT_CFG;
        else if (idx == IDX_IDENT) k = KIND_IDENT;
        else if (idx[5:4] == GRP_CHANNEL) k = KIND_CHANNEL;
        else if (idx[5:3] == GRP_SETUP) k = KIND_SETUP;
        else if (idx[5:3] == GRP_FILTER) k = KIND_FILTER;
        else if (idx[5:3] == GRP_OFFSET) k = KIND_OFFSET;
        else if (idx[5:3] == GRP_GAIN) k = KIND_GAIN;
        return k;
    endfunction : decode_kind

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_sync_q; // [0] feeds [1] only
    logic [1:0] cs_sync_n_q; // [0] feeds [1] only
    logic [1:0] din_sync_q; // [0] feeds [1] only
    logic sclk_prev_q; // last settled sclk, for edge finding

    // two flops per pin before any logic looks at it
    always_ff @(posedge sys_clk)
    begin
        sclk_sync_q <= {sclk_sync_q[0], sclk};
        cs_sync_n_q <= {cs_sync_n_q[0], cs_n};
        din_sync_q <= {din_sync_q[0], din};
        sclk_prev_q <= sclk_sync_q[1];
    end

    // ------------------------------------------------------------
    // byte assembly
    // ------------------------------------------------------------
    logic [CMD_WIDTH-2:0] shift_q; // first seven bits, msb first
    logic [CNT_WIDTH-1:0] bit_cnt_q; // bits of the current byte
    phase_t phase_q; // command or transfer phase

    wire cs_active = !cs_sync_n_q[1]; // frame open
    wire sclk_rise = sclk_sync_q[1] && !sclk_prev_q; // host data valid edge
    wire bit_take = cs_active && sclk_rise; // one bit per rising edge
    wire byte_done = bit_take && (bit_cnt_q == LAST_BIT);
    wire [CMD_WIDTH-1:0] rx_byte = {shift_q, din_sync_q[1]};
    // only a byte in the command phase is a command
    wire cmd_seen = byte_done && (phase_q == PH_COMMAND);
    wire start_ok = !rx_byte[START_BIT];
    wire cmd_accept = cmd_seen && start_ok;
    wire cmd_reject = cmd_seen && !start_ok;
    wire [5:0] rx_idx = rx_byte[IDX_MSB:0];
    wire target_kind_t rx_kind = decode_kind(rx_idx);
    // reserved codes still end the command but move no data
    wire rx_live = (rx_kind != KIND_NONE);
    wire rx_read = rx_byte[DIR_BIT];
    // channels use four bits, the grouped registers three
    wire [3:0] rx_num = (rx_kind == KIND_CHANNEL) ? rx_idx[3:0] : {1'b0, rx_idx[2:0]};
    // frame end or downstream completion closes the transfer
    wire xfer_end = !cs_active || xfer_done;

    // shift register and bit counter; counter restarts per frame
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !cs_active)
        begin
            shift_q <= CMD_RESET[CMD_WIDTH-2:0];
            bit_cnt_q <= LAST_BIT - LAST_BIT;
        end
        else if (bit_take)
        begin
            shift_q <= rx_byte[CMD_WIDTH-2:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // phase and command register
    // ------------------------------------------------------------
    phase_t phase_d;
    assign phase_d = (phase_q == PH_COMMAND) ? (cmd_accept ? PH_TRANSFER : PH_COMMAND)
                                              : (xfer_end ? PH_COMMAND : PH_TRANSFER);

    // phase: command wait until a valid byte, then one routed transfer
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            phase_q <= PH_COMMAND;
        else
            phase_q <= phase_d;
    end

    // latch the accepted command and its routing
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            command_q <= CMD_RESET;
            target_kind_q <= KIND_NONE;
            target_num_q <= NUM_RESET;
        end
        else if (cmd_accept)
        begin
            command_q <= rx_byte;
            target_kind_q <= rx_kind;
            target_num_q <= rx_live ? rx_num : NUM_RESET;
        end
    end

    // direction levels held through the transfer phase
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            read_active_q <= 1'b0;
            write_active_q <= 1'b0;
        end
        else if (cmd_accept)
        begin
            read_active_q <= rx_live && rx_read;
            write_active_q <= rx_live && !rx_read;
        end
        else if (phase_q == PH_TRANSFER && xfer_end)
        begin
            read_active_q <= 1'b0;
            write_active_q <= 1'b0;
        end
    end

    // one-cycle event pulses
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cmd_strobe_q <= 1'b0;
            bad_start_q <= 1'b0;
        end
        else
        begin
            cmd_strobe_q <= cmd_accept;
            bad_start_q <= cmd_reject;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_accepted;
        cmd_strobe_q && phase_q == PH_TRANSFER;
    endsequence

    sequence s_grouped(logic [2:0] grp);
        cmd_strobe_q && command_q[IDX_MSB:3] == grp;
    endsequence

    a_start_bit_low: assert property (cmd_strobe_q |-> !command_q[START_BIT])
        else $error("command accepted with start bit high");
    a_bad_stays_cmd: assert property (bad_start_q |-> phase_q == PH_COMMAND)
        else $error("bad start byte opened a transfer");
    a_read_dir: assert property (s_accepted ##0 command_q[DIR_BIT] |-> !write_active_q)
        else $error("read command raised write");
    a_write_dir: assert property (s_accepted ##0 !command_q[DIR_BIT] |-> !read_active_q)
        else $error("write command raised read");
    a_route_hold: assert property (phase_q == PH_TRANSFER && cs_active && !xfer_done
        |=> phase_q == PH_TRANSFER && $stable(target_kind_q) && $stable(target_num_q))
        else $error("routing changed inside a transfer");
    a_channel_map: assert property (cmd_strobe_q && command_q[IDX_MSB:4] == GRP_CHANNEL
        |-> target_kind_q == KIND_CHANNEL && target_num_q == command_q[3:0])
        else $error("channel code decoded wrongly");
    a_setup_map: assert property (s_grouped(GRP_SETUP)
        |-> target_kind_q == KIND_SETUP && target_num_q == {1'b0, command_q[2:0]})
        else $error("setup code decoded wrongly");
    a_filter_map: assert property (s_grouped(GRP_FILTER)
        |-> target_kind_q == KIND_FILTER && target_num_q == {1'b0, command_q[2:0]})
        else $error("filter code decoded wrongly");
    a_reserved_idle: assert property (s_accepted ##0 target_kind_q == KIND_NONE
        |-> !read_active_q && !write_active_q)
        else $error("reserved code raised an access");
    a_end_clears: assert property (phase_q == PH_TRANSFER && !cs_active
        |=> phase_q == PH_COMMAND && !read_active_q && !write_active_q)
        else $error("frame end did not close transfer");

endmodule : cmd_decoder

// *** tb/host_model.sv ***
/* host model: the serial controller facing the command decoder.
   assumes the bench calls its tasks at a sys_clk rise. */
`timescale 1ns/1ps

module host_model
(
    // system clock
    input wire logic sys_clk,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // sclk idles high, still between frames
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // wait n cycles, ends on a rise
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // open or close a frame; freed din flips so no stale bit lingers
    task automatic frame(input logic open);
        @(posedge sys_clk);
        cs_n <= ~open;
        if (!open)
            din <= ~din;
        tick(8);
    endtask : frame

    // msb first, din set while sclk low; returns on the eighth rise
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            if (i < 7)
                tick(8);
            sclk <= 1'b0;
            din <= b[i];
            tick(8);
            sclk <= 1'b1;
        end
    endtask : send_byte
endmodule : host_model

// *** tb/register_access_command_decoder_test.sv ***
/* self-checking bench for the command decoder.
   assumes host_model drives the serial pins. */
`timescale 1ns/1ps

module register_access_command_decoder_test;
    import cmd_decode_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n;
    logic xfer_done;
    logic sclk;
    logic cs_n;
    logic din;
    logic strobe;
    logic bad;
    logic rd;
    logic wr;
    logic [7:0] command_q;
    target_kind_t kind;
    logic [3:0] num;
    int fail_count = 0;
    int num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    // design under test; every pin reaches a bench signal
    cmd_decoder i_cmd_decoder (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .xfer_done(xfer_done),
        .command_q(command_q),
        .cmd_strobe_q(strobe),
        .bad_start_q(bad),
        .target_kind_q(kind),
        .target_num_q(num),
        .read_active_q(rd),
        .write_active_q(wr)
    );
    // host side of the serial link
    host_model i_host_model (
        .sys_clk(sys_clk),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // expected {kind, number}, worked out independently of the design;
    // single registers report the low three index bits as their number
    function automatic logic [7:0] decode(input logic [5:0] x);
        if (x[5:4] == 2'h1)
            return {KIND_CHANNEL, x[3:0]};
        if (x[5:4] == 2'h2)
            return {x[3] ? KIND_FILTER : KIND_SETUP, 1'b0, x[2:0]};
        if (x[5:4] == 2'h3)
            return {x[3] ? KIND_GAIN : KIND_OFFSET, 1'b0, x[2:0]};
        if (x[3] || x == 6'h05)
            return 8'h00;
        if (x[2:1] == 2'h3)
            return {x[0] ? KIND_IDENT : KIND_PORT_CFG, 1'b0, x[2:0]};
        return {4'(x[2:0]) + 4'h1, 1'b0, x[2:0]};
    endfunction : decode

    // bounded watch for either strobe, 40 cycles
    task automatic watch(output logic [1:0] got);
        got = 2'b00;
        for (int n = 0; n < 40 && got == 2'b00; n++)
        begin
            @(posedge sys_clk);
            #1;
            got = {strobe === 1'b1, bad === 1'b1};
        end
    endtask : watch

    // send a command and check every decoded output
    task automatic command(input logic [7:0] b);
        logic [1:0] got;
        logic [7:0] e;
        e = decode(b[5:0]);
        i_host_model.send_byte(b);
        watch(got);
        check("strobe", 8'(got), 8'h02);
        if (got != 2'b10)
            summarize();
        check("command", command_q, b);
        check("kind number", {kind, num}, e);
        check("read", 8'(rd), 8'(b[6] && e != 8'h00));
        check("write", 8'(wr), 8'(!b[6] && e != 8'h00));
        @(posedge sys_clk);
        #1;
        check("strobe width", 8'(strobe), 8'h00);
        i_host_model.tick(8);
    endtask : command

    // done pulse ends the transfer
    task automatic end_by_done();
        @(posedge sys_clk);
        xfer_done <= 1'b1;
        @(posedge sys_clk);
        xfer_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("done drop", 8'({rd, wr}), 8'h00);
        @(posedge sys_clk);
    endtask : end_by_done

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [1:0] got;
        reset_n = 1'b0;
        xfer_done = 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check("reset command", command_q, CMD_RESET);
        check("reset kind", {kind, num}, 8'h00);
        check("reset flags", 8'({rd, wr}), 8'h00);
        i_host_model.frame(1'b1);
        // every index, both directions spread over each group
        for (int i = 0; i < 64; i++)
        begin
            command({1'b0, 1'(i ^ (i >> 3)), 6'(i)});
            end_by_done();
        end
        $display("test all indices done");
        // high start bit refused, command kept
        i_host_model.send_byte(8'hd2);
        watch(got);
        check("bad start", 8'(got), 8'h01);
        check("command kept", command_q, 8'h3f);
        i_host_model.tick(8);
        command(8'h50);
        // bytes of the transfer phase are not decoded
        i_host_model.send_byte(8'h10);
        watch(got);
        check("transfer byte", 8'({got, rd, wr}), 8'h02);
        i_host_model.frame(1'b0);
        #1;
        check("frame drop", 8'({rd, wr}), 8'h00);
        $display("test refusal and frame end done");
        i_host_model.frame(1'b1);
        command(8'h2e);
        end_by_done();
        i_host_model.frame(1'b0);
        $display("test new frame done");
        summarize();
    end
endmodule : register_access_command_decoder_test
